// [hw/tvc_ctrl.sv]
// Two-wire slave holding a 7-bit trim setting, with non-volatile commit and restore.
`timescale 1ns/1ps
module tvc_ctrl #(
  parameter int unsigned PROG_CYCLES = tvc_pkg::NVM_PROG_CYC
) (
  input logic i_clk,
  input logic i_rstn,
  input logic i_scl,
  input logic i_scl_sw,
  input logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input logic i_nvm_write_enable_in,
  output logic o_protect_inverted_out,
  output logic [tvc_pkg::SET_W-1:0] o_setting,
  output logic [tvc_pkg::BYTE_W-1:0] o_level_num,
  output logic o_nvm_busy,
  output logic o_init_done
);
  import tvc_pkg::*;

  // ---------------- Pin level logic ----------------
  logic link_clk;
  logic link_rst_n;

  // relies on the operator silencing the original clock, so the mux needs no glitch guard.
  assign link_clk = i_nvm_write_enable_in ? i_scl_sw : i_scl;

  assign o_protect_inverted_out = ~i_nvm_write_enable_in;

  // open-drain data only, the clock is never driven.
  assign o_sda = 1'b0;

  // ---------------- System clock domain ----------------
  logic [2:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic we_s;
  logic sda_prev_q;
  logic frame_rst_q;
  logic start_w;
  logic stop_w;
  logic wr_tgl_s;
  logic wr_prev_q;
  logic wr_evt;
  tvc_state_t state_q;
  tvc_state_t state_d;
  logic [SET_W-1:0] setting_q;
  logic [SET_W-1:0] setting_d;
  logic [BYTE_W-1:0] level_q;
  logic [SET_W-1:0] nvm_data;
  logic prog_go;

  // Link domain registers read here.
  logic wr_tgl_q;
  tvc_byte_t wr_word_q;

  tvc_sync #(
    .WIDTH(3),
    .RST_VAL(PIN_SYNC_RESET_VAL)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d({link_clk, i_sda, i_nvm_write_enable_in}),
    .o_q(pins_s)
  );

  assign scl_s = pins_s[2];
  assign sda_s = pins_s[1];
  assign we_s = pins_s[0];
  assign start_w = scl_s && sda_prev_q && !sda_s;
  assign stop_w = scl_s && !sda_prev_q && sda_s;

  // The frame reset is held from a start or stop until the clock goes low, so its release
  // lands a few system clocks after the clock falls, once the low clock has passed the synchroniser.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sda_prev_q <= 1'b1;
      frame_rst_q <= 1'b1;
    end
    else
    begin
      sda_prev_q <= sda_s;
      frame_rst_q <= (start_w || stop_w) || (frame_rst_q && scl_s);
    end
  end

  tvc_sync #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_wr_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(wr_tgl_q),
    .o_q(wr_tgl_s)
  );

  // The written byte is held steady for a whole byte time after its toggle, so it is safe to take here.
  assign wr_evt = wr_tgl_s ^ wr_prev_q;
  assign state_d = ST_RUN;

  assign setting_d = (state_q == ST_LOAD) ? nvm_data : (wr_evt ? wr_word_q.setting : setting_q);

  assign prog_go = wr_evt && (state_q == ST_RUN) && (wr_word_q.pbit == PBIT_NVM) && we_s && !o_nvm_busy;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_prev_q <= 1'b0;
      state_q <= ST_LOAD;
      setting_q <= SETTING_RESET_VAL;
      level_q <= LEVEL_STEP;
    end
    else
    begin
      wr_prev_q <= wr_tgl_s;
      state_q <= state_d;
      setting_q <= setting_d;
      level_q <= {1'b0, setting_q} + LEVEL_STEP;
    end
  end

  tvc_nvm #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_nvm (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_prog(prog_go),
    .i_data(wr_word_q.setting),
    .o_data(nvm_data),
    .o_busy(o_nvm_busy)
  );

  assign o_setting = setting_q;
  assign o_level_num = level_q;
  assign o_init_done = (state_q == ST_RUN);

  // ---------------- Link clock domain ----------------
  logic [CNT_W-1:0] bit_cnt_q;
  logic [CNT_W-1:0] bit_cnt_d;
  logic [BYTE_W-1:0] shreg_q;
  logic [BYTE_W-1:0] shreg_d;
  tvc_phase_t phase_q;
  tvc_phase_t phase_d;
  tvc_byte_t tx_q;
  tvc_byte_t tx_d;
  tvc_byte_t rd_sync;
  logic sda_oe_q;
  logic sda_drive_d;
  logic ack_slot;
  logic addr_hit;
  logic dir_rd;
  logic tx_load;
  logic wr_fire;

  assign link_rst_n = i_rstn && !frame_rst_q;

  // readback byte with ready bit
  // The setting changes only through the start-up restore and writes on this bus, so the word is settled before a read frame.
  tvc_sync #(
    .WIDTH(BYTE_W),
    .RST_VAL({SETTING_RESET_VAL, PBIT_BUSY})
  ) u_rd_sync (
    .i_clk(link_clk),
    .i_rstn(i_rstn),
    .i_d({setting_q, (o_nvm_busy ? PBIT_BUSY : PBIT_READY)}),
    .o_q(rd_sync)
  );

  assign ack_slot = (bit_cnt_q == BIT_ACK);
  assign addr_hit = (shreg_q[7:1] == BUS_ADDR8[7:1]);
  assign dir_rd = (shreg_q[0] == DIR_READ);
  assign bit_cnt_d = ack_slot ? BIT_FIRST : bit_cnt_q + CNT_W'(1);
  assign shreg_d = ack_slot ? shreg_q : {shreg_q[6:0], i_sda};
  assign tx_load = ack_slot && (((phase_q == PH_ADDR) && addr_hit && dir_rd) || ((phase_q == PH_RD) && !i_sda));
  assign tx_d = tx_load ? rd_sync : tx_q;
  assign wr_fire = ack_slot && (phase_q == PH_WR);

  always_comb
  begin
    phase_d = phase_q;
    case (phase_q)
      PH_ADDR:
      begin
        if (ack_slot)
        begin
          phase_d = addr_hit ? (dir_rd ? PH_RD : PH_WR) : PH_IGN;
        end
      end
      PH_WR:
      begin
        phase_d = PH_WR;
      end
      PH_RD:
      begin
        if (ack_slot && i_sda)
        begin
          phase_d = PH_IGN;
        end
      end
      PH_IGN:
      begin
        phase_d = PH_IGN;
      end
      default:
      begin
        phase_d = PH_IGN;
      end
    endcase
  end

  // acknowledge only when addressed, read bits MSB first
  assign sda_drive_d = (ack_slot && (((phase_q == PH_ADDR) && addr_hit) || (phase_q == PH_WR)))
    || ((phase_q == PH_RD) && !ack_slot && !tx_q[~bit_cnt_q[2:0]]);

  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bit_cnt_q <= BIT_FIRST;
      shreg_q <= '0;
      phase_q <= PH_ADDR;
      tx_q <= '0;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_d;
      shreg_q <= shreg_d;
      phase_q <= phase_d;
      tx_q <= tx_d;
    end
  end

  // hand written byte to system domain
  always_ff @(posedge link_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_tgl_q <= 1'b0;
      wr_word_q <= '0;
    end
    else if (wr_fire)
    begin
      wr_tgl_q <= ~wr_tgl_q;
      wr_word_q <= shreg_q;
    end
  end

  // Data changes on the falling clock so it is stable through the master's rising-edge sample.
  always_ff @(negedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      sda_oe_q <= 1'b0;
    end
    else
    begin
      sda_oe_q <= sda_drive_d;
    end
  end

  assign o_sda_oe = sda_oe_q;

  // ---------------- Assertions ----------------
  sequence s_addr_rd_ack;
    (phase_q == PH_ADDR) && ack_slot && addr_hit && dir_rd;
  endsequence

  sequence s_nvm_req;
    wr_evt && (state_q == ST_RUN) && (wr_word_q.pbit == PBIT_NVM) && !o_nvm_busy;
  endsequence

  property p_protect_inv;
    @(posedge i_clk) disable iff (!i_rstn) o_protect_inverted_out != i_nvm_write_enable_in;
  endproperty
  a_protect_inv: assert property (p_protect_inv) else $error("protect output not inverse of write enable");

  property p_startup_load;
    @(posedge i_clk) disable iff (!i_rstn) (state_q == ST_LOAD) |=> (setting_q == $past(nvm_data)) && o_init_done;
  endproperty
  a_startup_load: assert property (p_startup_load) else $error("stored value not loaded at start-up");

  property p_write_setting;
    @(posedge i_clk) disable iff (!i_rstn) (wr_evt && (state_q == ST_RUN)) |=> (setting_q == $past(wr_word_q.setting));
  endproperty
  a_write_setting: assert property (p_write_setting) else $error("written setting not in volatile register");

  property p_level;
    @(posedge i_clk) disable iff (!i_rstn) (state_q == ST_RUN) |=> (o_level_num == {1'b0, $past(setting_q)} + LEVEL_STEP);
  endproperty
  a_level: assert property (p_level) else $error("level numerator not setting plus one");

  property p_refuse_nvm;
    @(posedge i_clk) disable iff (!i_rstn) (s_nvm_req and !we_s) |=> !o_nvm_busy;
  endproperty
  a_refuse_nvm: assert property (p_refuse_nvm) else $error("programming started while write enable low");

  property p_allow_nvm;
    @(posedge i_clk) disable iff (!i_rstn) (s_nvm_req and we_s) |=> o_nvm_busy [*2];
  endproperty
  a_allow_nvm: assert property (p_allow_nvm) else $error("programming not started on store request");

  property p_volatile_only;
    @(posedge i_clk) disable iff (!i_rstn) (wr_evt && (wr_word_q.pbit == PBIT_VOLATILE) && !o_nvm_busy) |=> !o_nvm_busy;
  endproperty
  a_volatile_only: assert property (p_volatile_only) else $error("volatile-only write started programming");

  property p_ignore_quiet;
    @(posedge link_clk) disable iff (!link_rst_n) (phase_q == PH_IGN) |-> !o_sda_oe;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("data line driven in ignored transfer");

  property p_read_load;
    @(posedge link_clk) disable iff (!link_rst_n) s_addr_rd_ack |=> (tx_q == $past(rd_sync)) && (phase_q == PH_RD);
  endproperty
  a_read_load: assert property (p_read_load) else $error("readback byte not loaded after address");

endmodule

// [hw/tvc_pkg.sv]
// Shared constants and types for the two-wire trim register with non-volatile store.
package tvc_pkg;

  // Setting and data byte widths.
  localparam int SET_W = 7;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 4;

  // Fixed bus address in 8-bit form; the low bit is the direction bit.
  localparam logic [7:0] BUS_ADDR8 = 8'h9E;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h0;

  // Meaning of the eighth data bit.
  localparam logic PBIT_VOLATILE = 1'b1;
  localparam logic PBIT_NVM = 1'b0;
  localparam logic PBIT_READY = 1'b1;
  localparam logic PBIT_BUSY = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // Values after reset.
  localparam logic [SET_W-1:0] NVM_RESET_VAL = 7'h00;
  localparam logic [SET_W-1:0] SETTING_RESET_VAL = 7'h00;
  localparam logic [2:0] PIN_SYNC_RESET_VAL = 3'h6;
  localparam logic [BYTE_W-1:0] LEVEL_STEP = 8'h01;

  // Timing: non-volatile programming time, a least time, rounded up.
  localparam int CLK_PERIOD_NS = 25;
  localparam int NVM_PROG_NS = 5000000;
  localparam int NVM_PROG_CYC = (NVM_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [SET_W-1:0] setting;
    logic pbit;
  } tvc_byte_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_WR = 2'b01,
    PH_RD = 2'b11,
    PH_IGN = 2'b10
  } tvc_phase_t;

  typedef enum logic {
    ST_LOAD = 1'b0,
    ST_RUN = 1'b1
  } tvc_state_t;

endpackage

// [hw/tvc_sync.sv]
// Two flip-flop synchroniser for levels entering a clock domain.
`timescale 1ns/1ps
module tvc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input logic i_clk,
  input logic i_rstn,
  input logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_q <= RST_VAL;
      o_q <= RST_VAL;
    end
    else
    begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule

// [hw/tvc_nvm.sv]
// Non-volatile setting store with a timed programming cycle.
`timescale 1ns/1ps
module tvc_nvm #(
  parameter int unsigned PROG_CYCLES = tvc_pkg::NVM_PROG_CYC
) (
  input logic i_clk,
  input logic i_rstn,
  input logic i_prog,
  input logic [tvc_pkg::SET_W-1:0] i_data,
  output logic [tvc_pkg::SET_W-1:0] o_data,
  output logic o_busy
);
  import tvc_pkg::*;

  localparam int CW = $clog2(PROG_CYCLES + 1);

  logic [CW-1:0] cnt_q;
  logic [SET_W-1:0] pend_q;
  // Power-on content of the store; a system reset must not touch it.
  logic [SET_W-1:0] store_q = NVM_RESET_VAL;
  logic last_w;

  assign last_w = (cnt_q == CW'(1));
  assign o_busy = (cnt_q != '0);
  assign o_data = store_q;

  // The stored word only changes at the end of the cycle, so an early power loss keeps the old value.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt_q <= '0;
      pend_q <= NVM_RESET_VAL;
    end
    else
    begin
      if (i_prog && !o_busy)
      begin
        cnt_q <= CW'(PROG_CYCLES);
        pend_q <= i_data;
      end
      else if (o_busy)
      begin
        cnt_q <= cnt_q - CW'(1);
      end
    end
  end

  // The stored word has no reset, so every start-up restores what was last committed.
  always_ff @(posedge i_clk)
  begin
    if (last_w)
    begin
      store_q <= pend_q;
    end
  end

endmodule

// [dv/tvc_i2c_master.sv]
// Behavioural two-wire bus master that faces the trim register.
`timescale 1ns/1ps
module tvc_i2c_master (
  output logic o_scl,
  output logic o_sda_oe,
  input wire logic i_sda
);
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic start();
    #20 o_sda_oe = 1'b0;
    #60 o_scl = 1'b1;
    #200 o_sda_oe = 1'b1;
    #200 o_scl = 1'b0;
  endtask

  task automatic stop();
    #20 o_sda_oe = 1'b1;
    #60 o_scl = 1'b1;
    #200 o_sda_oe = 1'b0;
    #200;
  endtask

  task automatic bit_io(input logic b, output logic s);
    #20 o_sda_oe = ~b;
    #60 o_scl = 1'b1;
    #40 s = i_sda;
    #40 o_scl = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] wb, input logic mack, output logic [7:0] rb, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(wb[i], rb[i]);
    bit_io(~mack, s);
    ack = ~s;
  endtask
endmodule

// [dv/tvc_ctrl_tb.sv]
// Self-checking bench for the two-wire trim register.
`timescale 1ns/1ps
module tvc_ctrl_tb;
  import tvc_pkg::*;
  // A long programming count lets a read land while the store is still busy.
  localparam int unsigned PROG = 400;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic we = 1'b0;
  logic m_scl;
  logic m_oe;
  logic d_sda;
  logic d_oe;
  logic protect;
  logic [SET_W-1:0] setting;
  logic [BYTE_W-1:0] level;
  logic busy;
  logic init_done;
  logic aa;
  logic ad;
  logic [7:0] rb;
  int cyc = 0;
  int err_total = 0;
  int cmp_count = 0;
  wire logic sda = ~(m_oe | (d_oe & ~d_sda));
  wire logic scl = we ? 1'b1 : m_scl;
  wire logic scl_sw = we ? m_scl : 1'b1;

  tvc_i2c_master u_tvc_i2c_master (.o_scl(m_scl), .o_sda_oe(m_oe), .i_sda(sda));

  tvc_ctrl #(.PROG_CYCLES(PROG)) u_tvc_ctrl (
    .i_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_scl_sw(scl_sw),
    .i_sda(sda), .o_sda(d_sda), .o_sda_oe(d_oe),
    .i_nvm_write_enable_in(we), .o_protect_inverted_out(protect),
    .o_setting(setting), .o_level_num(level), .o_nvm_busy(busy),
    .o_init_done(init_done)
  );

  always #12.5 clk = ~clk;

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      summarize();
    end
  end

  task automatic summarize();
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic set_we(input logic v);
    @(posedge clk);
    #2 we = v;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] junk;
    u_tvc_i2c_master.start();
    u_tvc_i2c_master.xfer(a, 1'b0, junk, aa);
    u_tvc_i2c_master.xfer(d, 1'b0, junk, ad);
    u_tvc_i2c_master.stop();
    settle(8);
  endtask

  task automatic rd();
    logic j;
    u_tvc_i2c_master.start();
    u_tvc_i2c_master.xfer(BUS_ADDR8 | 8'h01, 1'b0, rb, aa);
    u_tvc_i2c_master.xfer(8'hFF, 1'b0, rb, j);
    u_tvc_i2c_master.stop();
    settle(8);
  endtask

  task automatic chk_set(input logic [SET_W-1:0] s);
    chk("setting", {1'b0, setting}, {1'b0, s});
    chk("level", level, {1'b0, s} + 8'h01);
  endtask

  task automatic t_reset();
    chk("init", {7'h00, init_done}, 8'h01);
    chk_set(NVM_RESET_VAL);
    chk("busy", {7'h00, busy}, 8'h00);
    chk("protect", {7'h00, protect}, 8'h01);
    set_we(1'b1);
    settle(1);
    chk("protect", {7'h00, protect}, 8'h00);
    set_we(1'b0);
  endtask

  task automatic t_volatile();
    wr(BUS_ADDR8, {7'h55, PBIT_VOLATILE});
    chk("addr ack", {7'h00, aa}, 8'h01);
    chk("data ack", {7'h00, ad}, 8'h01);
    chk_set(7'h55);
    chk("busy", {7'h00, busy}, 8'h00);
    rd();
    chk("readback", rb, {7'h55, PBIT_READY});
  endtask

  task automatic t_blocked();
    wr(BUS_ADDR8, {7'h2A, PBIT_NVM});
    chk("data ack", {7'h00, ad}, 8'h01);
    chk_set(7'h2A);
    chk("busy", {7'h00, busy}, 8'h00);
    rd();
    chk("readback", rb, {7'h2A, PBIT_READY});
  endtask

  task automatic t_foreign();
    logic [7:0] addrs [3] = '{8'hA0, 8'h1E, 8'h9C};
    foreach (addrs[i])
    begin
      wr(addrs[i], {7'h11, PBIT_VOLATILE});
      chk("foreign ack", {7'h00, aa}, 8'h00);
      chk_set(7'h2A);
    end
  endtask

  task automatic t_store();
    int n;
    set_we(1'b1);
    wr(BUS_ADDR8, {7'h7F, PBIT_VOLATILE});
    chk("addr ack", {7'h00, aa}, 8'h01);
    chk_set(7'h7F);
    chk("busy", {7'h00, busy}, 8'h00);
    wr(BUS_ADDR8, {7'h33, PBIT_NVM});
    chk_set(7'h33);
    chk("busy", {7'h00, busy}, 8'h01);
    rd();
    chk("readback", rb, {7'h33, PBIT_BUSY});
    n = 0;
    while (busy === 1'b1 && n < 2 * PROG)
    begin
      settle(1);
      n++;
    end
    chk("busy", {7'h00, busy}, 8'h00);
    rd();
    chk("readback", rb, {7'h33, PBIT_READY});
    set_we(1'b0);
  endtask

  // A second reset in mid-run must bring back the committed setting.
  task automatic t_restart();
    @(posedge clk);
    #2 rstn = 1'b0;
    settle(3);
    chk("init", {7'h00, init_done}, 8'h00);
    chk_set(SETTING_RESET_VAL);
    rstn = 1'b1;
    settle(1);
    chk("init", {7'h00, init_done}, 8'h01);
    chk("setting", {1'b0, setting}, 8'h33);
    chk("level", level, LEVEL_STEP);
    settle(1);
    chk_set(7'h33);
    chk("busy", {7'h00, busy}, 8'h00);
    rd();
    chk("readback", rb, {7'h33, PBIT_READY});
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    #2 rstn = 1'b1;
    settle(6);
    t_reset();
    t_volatile();
    t_blocked();
    t_foreign();
    t_store();
    t_restart();
    summarize();
  end
endmodule
